// File: bench/spims_core_sva.sv
// checker: concurrent properties on the spi port pins, status flags and interrupt
`timescale 1ns/10ps
module spims_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire spims_pkg::spims_ctrl_t ctrl,
  input wire logic writeStrobe,
  input wire logic clearOverrun,
  input wire logic selectIn_n,
  input wire spims_pkg::spims_stat_t status,
  input wire logic interruptOut,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HIZ: assert property (
    (!ctrl.enable) [*2] |-> !misoOe && !mosiOe) else $error("pin driven");
  AST_UNSEL: assert property (
    (ctrl.enable && !ctrl.master && selectIn_n) [*4] |-> !misoOe)
    else $error("miso driven unselected");
  AST_MISO_IN: assert property (
    ctrl.master [*2] |-> !misoOe) else $error("master drives miso");
  AST_SLV_IN: assert property (
    (!ctrl.master) [*2] |-> !mosiOe && !sckOe) else $error("slave drives");
  AST_OVR: assert property (
    writeStrobe && status.busy |=> status.overrun) else $error("no overrun");
  AST_OVR_CLR: assert property (
    status.overrun && clearOverrun && !writeStrobe |=> !status.overrun)
    else $error("overrun kept");
  AST_COL: assert property (
    (ctrl.enable && ctrl.master && !selectIn_n) [*5] |-> status.collision)
    else $error("no collision");
  AST_IRQ: assert property (
    1'b1 |-> interruptOut == (status.irq && ctrl.interruptEnable))
    else $error("irq output wrong");
  AST_STR: assert property (
    ctrl.forceStartupIrq |-> ##[0:2] status.irq) else $error("no startup");
  AST_DONE: assert property (
    $rose(status.busy) && ctrl.master |-> ##[1:1000] !status.busy)
    else $error("transfer hung");
  AST_ABT: assert property (
    status.busy && !ctrl.master && $rose(selectIn_n) |->
    ##[1:5] status.abort && status.irq) else $error("no abort");
  COV_OVR: cover property (writeStrobe && status.busy);
  COV_ABT: cover property ($rose(status.abort));
  COV_COL: cover property ($rose(status.collision));
endmodule

bind spims_core spims_sva chk (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
  .writeStrobe(writeStrobe), .clearOverrun(clearOverrun),
  .selectIn_n(selectIn_n), .status(status), .interruptOut(interruptOut),
  .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe));

// File: bench/spims_peer.sv
// partner: far-side spi device in slave or master role
`timescale 1ns/10ps
module spims_peer (
  input wire logic clk,
  input wire logic peerMaster,
  input wire logic sckLine,
  input wire logic mosiLine,
  input wire logic misoLine,
  output logic sckDrv,
  output logic mosiDrv,
  output logic misoDrv,
  output logic selDrv_n
);
  logic [7:0] txShift = 8'h00;
  logic [7:0] rxShift = 8'h00;
  initial begin
    sckDrv = 1'b0;
    mosiDrv = 1'b0;
    selDrv_n = 1'b1;
  end
  // slave role, mode 0: sample rising, shift falling
  always @(posedge sckLine) begin
    if (!peerMaster) rxShift <= {rxShift[6:0], mosiLine};
  end
  always @(negedge sckLine) begin
    if (!peerMaster) txShift <= {txShift[6:0], ~txShift[7]};
  end
  // released miso shows inverse of last bit, never a stale level
  assign misoDrv = peerMaster ? ~rxShift[0] : txShift[7];
  task load(input logic [7:0] d);
    txShift = d;
  endtask
  task sel(input logic v);
    @(posedge clk);
    selDrv_n <= v;
  endtask
  // master role: half period six sysclks keeps sck period above eight
  task xfer(input logic [7:0] d, input int bits, input logic useSel);
    int i;
    txShift = d;
    @(posedge clk);
    selDrv_n <= !useSel;
    mosiDrv <= d[7];
    for (i = 0; i < bits; i++) begin
      repeat (6) @(posedge clk);
      sckDrv <= 1'b1;
      rxShift <= {rxShift[6:0], misoLine};
      repeat (6) @(posedge clk);
      sckDrv <= 1'b0;
      txShift <= {txShift[6:0], 1'b0};
      mosiDrv <= txShift[6];
    end
    repeat (6) @(posedge clk);
    selDrv_n <= 1'b1;
    mosiDrv <= ~mosiDrv;
  endtask
endmodule

// File: bench/test_spi_master_slave_port.sv
// testbench: directed scenarios for the spi port
`timescale 1ns/10ps
module test_spi_master_slave_port;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  spims_pkg::spims_ctrl_t ctrl = '0;
  spims_pkg::spims_stat_t st;
  logic [7:0] wd = 8'h00;
  logic ws = 1'b0, cO = 1'b0, cC = 1'b0, cA = 1'b0, cI = 1'b0;
  logic rxReady = 1'b0, pMaster = 1'b0;
  logic [7:0] dreg, rxData;
  logic rxValid, intr, sckO, sckOe, mosiO, mosiOe, misoO, misoOe;
  logic pSck, pMosi, pMiso, pSel_n;
  wire sckL = sckOe ? sckO : pSck;
  wire mosiL = mosiOe ? mosiO : pMosi;
  wire misoL = misoOe ? misoO : pMiso;
  int bad_count = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  spims_core uut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
    .baudDivisorHigh(8'h00), .baudDivisorLow(8'h04), .writeData(wd),
    .writeStrobe(ws), .clearOverrun(cO), .clearCollision(cC),
    .clearAbort(cA), .clearIrq(cI), .spiDataReg(dreg), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .status(st), .interruptOut(intr),
    .sckIn(sckL), .sckOut(sckO), .sckOe(sckOe), .mosiIn(mosiL),
    .mosiOut(mosiO), .mosiOe(mosiOe), .misoIn(misoL), .misoOut(misoO),
    .misoOe(misoOe), .selectIn_n(pSel_n));
  spims_peer peer (.clk(clk), .peerMaster(pMaster), .sckLine(sckL),
    .mosiLine(mosiL), .misoLine(misoL), .sckDrv(pSck), .mosiDrv(pMosi),
    .misoDrv(pMiso), .selDrv_n(pSel_n));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] d);
    @(posedge clk);
    wd <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask
  task idle;
    int n;
    repeat (3) @(posedge clk);
    for (n = 0; n < 2000 && st.busy !== 1'b0; n++) @(posedge clk);
    if (n == 2000) begin
      bad_count++;
      test_done;
    end
  endtask
  task pop;
    @(posedge clk);
    rxReady <= 1'b1;
    @(posedge clk);
    rxReady <= 1'b0;
    #1;
  endtask
  task clrAll;
    @(posedge clk);
    {cO, cC, cA, cI} <= 4'hf;
    @(posedge clk);
    {cO, cC, cA, cI} <= 4'h0;
    @(posedge clk);
  endtask
  task tReset;
    chk({5'h00, misoOe, mosiOe, sckOe}, 8'h00);
    chk({2'b00, st}, 8'h00);
    chk(dreg, 8'h00);
  endtask
  task tStartup;
    @(posedge clk);
    ctrl.forceStartupIrq <= 1'b1;
    @(posedge clk);
    ctrl.forceStartupIrq <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, st.irq}, 8'h01);
    clrAll;
    chk({7'h00, st.irq}, 8'h00);
  endtask
  task tMaster;
    @(posedge clk);
    ctrl.enable <= 1'b1;
    ctrl.master <= 1'b1;
    ctrl.interruptEnable <= 1'b1;
    peer.load(8'h3c);
    wr(8'ha5);
    repeat (4) @(posedge clk);
    wr(8'h11);
    idle;
    chk(peer.rxShift, 8'ha5);
    chk(rxData, 8'h3c);
    chk({7'h00, st.overrun}, 8'h01);
    chk({7'h00, dreg === 8'h11}, 8'h00);
    chk({7'h00, intr}, 8'h01);
    pop;
    clrAll;
    chk({7'h00, st.overrun}, 8'h00);
  endtask
  task tCollision;
    peer.sel(1'b0);
    repeat (6) @(posedge clk);
    chk({7'h00, st.collision}, 8'h01);
    peer.sel(1'b1);
    repeat (3) @(posedge clk);
    clrAll;
    chk({7'h00, st.collision}, 8'h00);
  endtask
  task tFifo;
    int i;
    for (i = 0; i < 16; i++) begin
      peer.load(8'(i));
      wr(8'(~i));
      idle;
    end
    for (i = 0; i < 16; i++) begin
      chk({7'h00, rxValid}, 8'h01);
      chk(rxData, 8'(i));
      pop;
    end
    chk({7'h00, rxValid}, 8'h00);
  endtask
  task tBits;
    @(posedge clk);
    ctrl.numBits <= 4'h4;
    peer.load(8'h90);
    wr(8'h5c);
    idle;
    chk({4'h0, peer.rxShift[3:0]}, 8'h05);
    chk(rxData, 8'hc9);
    pop;
    @(posedge clk);
    ctrl.numBits <= 4'h0;
  endtask
  task tSlave;
    @(posedge clk);
    ctrl.master <= 1'b0;
    ctrl.bidirIrq <= 1'b1;
    ctrl.selectValue <= 1'b1;
    pMaster <= 1'b1;
    wr(8'h96);
    peer.xfer(8'hff, 8, 1'b0);
    peer.xfer(8'h5a, 8, 1'b1);
    repeat (4) @(posedge clk);
    chk(peer.rxShift, 8'h96);
    chk(rxData, 8'h5a);
    pop;
    chk({7'h00, rxValid}, 8'h00);
    clrAll;
  endtask
  task tAbort;
    wr(8'hc3);
    peer.xfer(8'h00, 3, 1'b1);
    repeat (4) @(posedge clk);
    chk({6'h00, st.abort, st.irq}, 8'h03);
    clrAll;
    chk({7'h00, st.abort}, 8'h00);
    while (rxValid === 1'b1) pop;
    wr(8'hc3);
    peer.xfer(8'h77, 8, 1'b1);
    chk(peer.rxShift, 8'hc3);
    chk(rxData, 8'h77);
  endtask
  initial begin
    #400000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tReset;
    tStartup;
    tMaster;
    tCollision;
    tFifo;
    tBits;
    tSlave;
    tAbort;
    test_done;
  end
endmodule

// File: hdl/spims_core.sv
// module: spi master/slave port with received-data fifo
// Overview of operation
// - shift out and in simultaneously, ring
// - single buffer: load only when idle; received data queues in fifo
// - miso input as master, output as slave, msb
// - mosi output as master, input as slave, msb
// - unselected slave leaves miso undriven
// - disabled block leaves miso and mosi undriven
// - master drives sck from baud generator
// - slave samples data on received sck
// - slave ignores sck unless selected
// - synchronise spi inputs before use
// - slave applies phase, polarity, wired-or, bits
// - start bit forces startup interrupt
// - slave ignores bidir irq and select value
// - slave leaves baud generator unused
// - unloaded slave shifts current data register
// - write during transfer: keep data, set overrun
// - select asserted on master sets collision
// - select loss mid-character aborts, sets flags
// - completion raises interrupt when enabled
`timescale 1ns/10ps
module spims_core #(
  parameter int FIFO_W = spims_pkg::DATA_W,
  parameter int FIFO_D = spims_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire spims_pkg::spims_ctrl_t ctrl,
  input wire logic [7:0] baudDivisorHigh,
  input wire logic [7:0] baudDivisorLow,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic clearOverrun,
  input wire logic clearCollision,
  input wire logic clearAbort,
  input wire logic clearIrq,
  output logic [7:0] spiDataReg,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output spims_pkg::spims_stat_t status,
  output logic interruptOut,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic selectIn_n
);
  typedef enum logic [1:0] {SPIMS_IDLE, SPIMS_RUN, SPIMS_DONE} spims_st_t;
  spims_st_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic [15:0] baudCnt_reg;
  logic sckInt_reg;
  logic [1:0] sckSync_reg;
  logic [1:0] mosiSync_reg;
  logic [1:0] misoSync_reg;
  logic [1:0] selSync_reg;
  logic sckPrev_reg;
  logic selPrev_reg;
  logic overrun_reg;
  logic collision_reg;
  logic abort_reg;
  logic irq_reg;
  logic startReq_reg;
  logic fifoInReady;
  logic fifoPush;
  logic [3:0] charBits;
  logic isMaster;
  logic selected;
  logic selRise;
  logic sckSlv;
  logic slvLead;
  logic slvTrail;
  logic baudTick;
  logic mstLead;
  logic mstTrail;
  logic lead;
  logic trail;
  logic serialIn;
  logic lastBit;
  logic [15:0] baudDiv;

  // outgoing bit, launched apart from the sampling edge
  logic txBit_reg;
  logic sampleEdge;
  logic shiftEdge;


  // zero or out-of-range count means a full eight-bit character;
  // counts above eight would run past the shift register
  function automatic logic [3:0] bitsPerChar(input logic [3:0] code);
    if (code == 4'h0 || code > 4'h8) begin
      return 4'h8;
    end
    return code;
  endfunction

  assign isMaster = ctrl.master;
  assign charBits = bitsPerChar(ctrl.numBits);
  assign baudDiv = {baudDivisorHigh, baudDivisorLow};

  // two-flop synchronisers; only second stage feeds logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckSync_reg <= 2'h0;
      mosiSync_reg <= 2'h0;
      misoSync_reg <= 2'h0;
      selSync_reg <= 2'h3;
    end else begin
      sckSync_reg <= {sckSync_reg[0], sckIn};
      mosiSync_reg <= {mosiSync_reg[0], mosiIn};
      misoSync_reg <= {misoSync_reg[0], misoIn};
      selSync_reg <= {selSync_reg[0], selectIn_n};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckPrev_reg <= 1'b0;
      selPrev_reg <= 1'b0;
    end else begin
      sckPrev_reg <= sckSync_reg[1];
      selPrev_reg <= selected;
    end
  end

  assign selected = !selSync_reg[1];
  assign selRise = selected && !selPrev_reg;
  // polarity folded in so edges are lead/trail regardless of idle level
  assign sckSlv = sckSync_reg[1] ^ ctrl.clockPolarity;
  // sck ignored unless selected
  assign slvLead = selected && sckSlv &&
    !(sckPrev_reg ^ ctrl.clockPolarity);
  assign slvTrail = selected && !sckSlv &&
    (sckPrev_reg ^ ctrl.clockPolarity);

  // baud generator runs only as master
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_reg <= 16'h0000;
    end else if (!isMaster || state_reg == SPIMS_IDLE) begin
      // keeps running through done so the closing half period ends
      baudCnt_reg <= 16'h0000;
    end else if (baudTick) begin
      baudCnt_reg <= 16'h0000;
    end else begin
      baudCnt_reg <= baudCnt_reg + 16'h0001;
    end
  end
  // divisor below one still yields a half period of one cycle
  assign baudTick = (baudCnt_reg + 16'h0001 >= baudDiv);
  assign mstLead = baudTick && !sckInt_reg;
  assign mstTrail = baudTick && sckInt_reg;
  assign lead = isMaster ? mstLead : slvLead;
  assign trail = isMaster ? mstTrail : slvTrail;
  assign serialIn = isMaster ? misoSync_reg[1] : mosiSync_reg[1];
  assign lastBit = (bitCnt_reg == charBits - 4'h1);
  // phase picks which edge samples; the other one launches
  assign sampleEdge = ctrl.clockPhase ? trail : lead;
  assign shiftEdge = ctrl.clockPhase ? lead : trail;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckInt_reg <= 1'b0;
    end else if (!isMaster || state_reg == SPIMS_IDLE) begin
      sckInt_reg <= 1'b0;
    end else if (baudTick) begin
      sckInt_reg <= !sckInt_reg;
    end
  end

  // transfer state: sample on one edge, shift on the other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPIMS_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= spims_pkg::DATA_RESET;
    end else if (!ctrl.enable) begin
      state_reg <= SPIMS_IDLE;
      bitCnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        SPIMS_IDLE: begin
          bitCnt_reg <= 4'h0;
          if (isMaster && startReq_reg && fifoInReady) begin
            shift_reg <= spiDataReg;
            state_reg <= SPIMS_RUN;
          end else if (!isMaster && selRise && fifoInReady) begin
            shift_reg <= spiDataReg;
            state_reg <= SPIMS_RUN;
          end
        end
        SPIMS_RUN: begin
          if (!isMaster && !selected) begin
            state_reg <= SPIMS_IDLE;
          end else if (sampleEdge) begin
            shift_reg <= {shift_reg[6:0], serialIn};
            if (lastBit) begin
              state_reg <= SPIMS_DONE;
            end else begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        SPIMS_DONE: begin
          // wait for the closing edge so the clock returns idle
          if (isMaster ? (ctrl.clockPhase ? 1'b1 : trail) : 1'b1) begin
            state_reg <= SPIMS_IDLE;
          end
        end
      endcase
    end
  end

  // received character goes into the fifo when complete
  assign fifoPush = (state_reg == SPIMS_RUN) &&
    sampleEdge && lastBit &&
    (isMaster || selected);

  spims_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) rxFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inData({shift_reg[6:0], serialIn}),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(rxData),
    .outValid(rxValid),
    .outReady(rxReady)
  );

  // launch register: data never changes on the far side's sampling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBit_reg <= 1'b0;
    end else if (state_reg == SPIMS_IDLE) begin
      txBit_reg <= spiDataReg[7];
    end else if (state_reg == SPIMS_RUN && shiftEdge) begin
      txBit_reg <= shift_reg[7];
    end
  end

  // data register: writes refused while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spiDataReg <= spims_pkg::DATA_RESET;
    end else if (writeStrobe && state_reg == SPIMS_IDLE) begin
      spiDataReg <= writeData;
    end
  end

  // start held until run, so a full fifo only delays it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startReq_reg <= 1'b0;
    end else if (!ctrl.enable || !isMaster) begin
      startReq_reg <= 1'b0;
    end else if (writeStrobe && state_reg == SPIMS_IDLE) begin
      startReq_reg <= 1'b1;
    end else if (state_reg == SPIMS_RUN) begin
      startReq_reg <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (writeStrobe && state_reg != SPIMS_IDLE) begin
      overrun_reg <= 1'b1;
    end else if (clearOverrun) begin
      overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      collision_reg <= 1'b0;
    // no filtering: one synchronised cycle of select is a fault
    end else if (ctrl.enable && isMaster && selected) begin
      collision_reg <= 1'b1;
    end else if (clearCollision) begin
      collision_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
    end else if (ctrl.enable && !isMaster && state_reg == SPIMS_RUN &&
        !selected) begin
      abort_reg <= 1'b1;
    end else if (clearAbort) begin
      abort_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else if (ctrl.forceStartupIrq) begin
      irq_reg <= 1'b1;
    // an aborted character also counts as complete
    end else if (fifoPush || (ctrl.enable && !isMaster &&
        state_reg == SPIMS_RUN && !selected)) begin
      irq_reg <= 1'b1;
    end else if (clearIrq) begin
      irq_reg <= 1'b0;
    end
  end

  // bidir irq and select value have no effect in slave mode
  assign interruptOut = irq_reg && ctrl.interruptEnable &&
    (isMaster ? 1'b1 : 1'b1);

  // pin drivers; wired-or drives mosi and miso only low, sck both ways
  always_comb begin
    sckOut = sckInt_reg ^ ctrl.clockPolarity;
    sckOe = ctrl.enable && isMaster;
    mosiOut = txBit_reg;
    mosiOe = ctrl.enable && isMaster &&
      (!ctrl.wiredOr || !txBit_reg);
    misoOut = txBit_reg;
    misoOe = ctrl.enable && !isMaster && selected &&
      (!ctrl.wiredOr || !txBit_reg);
  end

  assign status = '{busy: (state_reg != SPIMS_IDLE), irq: irq_reg,
    overrun: overrun_reg, collision: collision_reg, abort: abort_reg,
    selected: selected};
endmodule

// File: hdl/spims_fifo.sv
// module: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module spims_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
      end
      if (pop) begin
        rdPtr_reg <= AW'(rdPtr_reg + 1'b1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// File: hdl/spims_pkg.sv
// package: constants and carriers for the spi master/slave port
package spims_pkg;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0002;
  localparam int SLAVE_MIN_SCK_SYSCLK = 8;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic enable;
    logic master;
    logic clockPhase;
    logic clockPolarity;
    logic wiredOr;
    logic interruptEnable;
    logic bidirIrq;
    logic forceStartupIrq;
    logic selectValue;
    logic [3:0] numBits;
  } spims_ctrl_t;

  typedef struct packed {
    logic busy;
    logic irq;
    logic overrun;
    logic collision;
    logic abort;
    logic selected;
  } spims_stat_t;
endpackage
